// file: common/hot_swap_pkg.sv
// Package with timing constants, encodings and states for the hot swap sequencer
package hot_swap_pkg;
  localparam int unsigned CLOCK_MHZ = 125;
  // Glitch filter time on the enable request, in ns
  localparam int unsigned ENABLE_FILTER_NS = 3000;
  localparam int unsigned ENABLE_FILTER_CYCLES = (ENABLE_FILTER_NS * CLOCK_MHZ) / 1000;
  localparam int unsigned FILTER_CNT_W = 9;
  localparam logic [FILTER_CNT_W-1:0] FILTER_CNT_RESET = 9'h000;

  // Timing node current source select, one hot
  typedef enum logic [4:0] {
    TIMER_UP_5UA = 5'h01,
    TIMER_UP_60UA = 5'h02,
    TIMER_DOWN_2UA = 5'h04,
    TIMER_DOWN_100UA = 5'h08,
    TIMER_NONE = 5'h10
  } timer_sel_t;

  // Gate drive mode, one hot
  typedef enum logic [4:0] {
    GATE_HOLD_25MA = 5'h01,
    GATE_PULL_UP = 5'h02,
    GATE_REGULATE = 5'h04,
    GATE_FULL_ON = 5'h08,
    GATE_STRONG_DOWN = 5'h10
  } gate_mode_t;

  typedef enum logic [3:0] {
    ST_RESET = 4'h0,
    ST_INIT_CHARGE = 4'h1,
    ST_INIT_DISCHARGE = 4'h2,
    ST_OFF = 4'h3,
    ST_RAMP = 4'h4,
    ST_FAULT_TIMING = 4'h5,
    ST_ON = 4'h6,
    ST_FAULT = 4'h7,
    ST_COOLDOWN = 4'h8
  } seq_state_t;

  localparam seq_state_t STATE_RESET = ST_RESET;
  localparam timer_sel_t TIMER_RESET = TIMER_DOWN_100UA;
  localparam gate_mode_t GATE_RESET = GATE_HOLD_25MA;
endpackage

// file: common/sense_if.sv
// Interface carrying the synchronized comparator levels inside the block
`timescale 1ns/1ps
`default_nettype none
interface sense_if;
  logic supply_ok;
  logic enable_filt;
  logic fault_timing;
  logic linear_limit;
  logic fast_trip;
  logic timer_upper;
  logic timer_lower;
  modport source (output supply_ok, enable_filt, fault_timing, linear_limit, fast_trip, timer_upper, timer_lower);
  modport sink (input supply_ok, enable_filt, fault_timing, linear_limit, fast_trip, timer_upper, timer_lower);
endinterface
`default_nettype wire

// file: logic/sync_filter.sv
// Two-flop synchronizer with optional stable-time glitch filter
`timescale 1ns/1ps
`default_nettype none
module sync_filter #(
  parameter int unsigned FILTER_CYCLES = 0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic async_in,
  output logic sync_out
);
  import hot_swap_pkg::*;
  logic meta_r;
  logic stable_r;
  logic [FILTER_CNT_W-1:0] cnt_r;

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_r <= 1'b0;
      stable_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_in;
      stable_r <= meta_r;
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cnt_r <= FILTER_CNT_RESET;
      sync_out <= 1'b0;
    end
    else if (FILTER_CYCLES == 0)
      sync_out <= stable_r;
    else if (stable_r == sync_out)
      cnt_r <= FILTER_CNT_RESET;
    else if (cnt_r == FILTER_CNT_W'(FILTER_CYCLES - 1))
    begin
      cnt_r <= FILTER_CNT_RESET;
      sync_out <= stable_r;
    end
    else
      cnt_r <= cnt_r + 1'b1;
  end
endmodule
`default_nettype wire

// file: logic/hot_swap_sequencer.sv
// Hot swap sequencer: lockout, initial timing, start, fault timing, retry
`timescale 1ns/1ps
`default_nettype none
module hot_swap_sequencer (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic supply_lockout_ok,
  input wire logic enable_request,
  input wire logic sense_fault_timing,
  input wire logic sense_linear_limit,
  input wire logic sense_fast_trip,
  input wire logic timing_upper_threshold,
  input wire logic timing_lower_threshold,
  input wire logic auto_retry,
  output hot_swap_pkg::timer_sel_t timer_sel,
  output hot_swap_pkg::gate_mode_t gate_mode,
  output logic fault_flag,
  output logic power_good
);
  import hot_swap_pkg::*;

  sense_if sense ();
  seq_state_t state_r;
  seq_state_t state_nxt;
  logic enable_prev_r;
  logic enable_rise;
  logic retry_mode_r;
  logic strap_taken_r;

  // Comparator inputs through synchronizers
  sync_filter #(.FILTER_CYCLES(0)) u_sync_supply (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(supply_lockout_ok),
    .sync_out(sense.supply_ok)
  );
  sync_filter #(.FILTER_CYCLES(ENABLE_FILTER_CYCLES)) u_sync_enable (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(enable_request),
    .sync_out(sense.enable_filt)
  );
  sync_filter #(.FILTER_CYCLES(0)) u_sync_ftime (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(sense_fault_timing),
    .sync_out(sense.fault_timing)
  );
  sync_filter #(.FILTER_CYCLES(0)) u_sync_limit (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(sense_linear_limit),
    .sync_out(sense.linear_limit)
  );
  sync_filter #(.FILTER_CYCLES(0)) u_sync_fast (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(sense_fast_trip),
    .sync_out(sense.fast_trip)
  );
  sync_filter #(.FILTER_CYCLES(0)) u_sync_upper (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(timing_upper_threshold),
    .sync_out(sense.timer_upper)
  );
  sync_filter #(.FILTER_CYCLES(0)) u_sync_lower (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(timing_lower_threshold),
    .sync_out(sense.timer_lower)
  );

  // Variant strap caught after reset release through a synchronizer
  logic retry_sync;
  sync_filter #(.FILTER_CYCLES(0)) u_sync_retry (
    .clock(clock),
    .rst_b(rst_b),
    .async_in(auto_retry),
    .sync_out(retry_sync)
  );

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      strap_taken_r <= 1'b0;
      retry_mode_r <= 1'b0;
    end
    else if (state_r == ST_RESET)
    begin
      strap_taken_r <= 1'b1;
      retry_mode_r <= retry_sync;
    end
  end

  // Edge detect on filtered enable
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      enable_prev_r <= 1'b0;
    else
      enable_prev_r <= sense.enable_filt;
  end

  assign enable_rise = sense.enable_filt && !enable_prev_r;

  // Next state
  always_comb
  begin
    state_nxt = state_r;
    if (!sense.supply_ok)
      state_nxt = ST_RESET;
    else
    begin
      unique case (state_r)
        ST_RESET:
          if (strap_taken_r)
            state_nxt = ST_INIT_CHARGE;
        ST_INIT_CHARGE:
          if (sense.timer_lower)
            state_nxt = ST_INIT_DISCHARGE;
        ST_INIT_DISCHARGE:
          if (!sense.timer_lower)
            state_nxt = sense.enable_filt ? ST_RAMP : ST_OFF;
        ST_OFF:
          if (enable_rise)
            state_nxt = ST_RAMP;
        ST_RAMP, ST_FAULT_TIMING, ST_ON:
        begin
          if (!sense.enable_filt)
            state_nxt = ST_OFF;
          else if (state_r == ST_FAULT_TIMING && sense.fault_timing && sense.timer_upper)
            state_nxt = ST_FAULT;
          else if (sense.fault_timing)
            state_nxt = ST_FAULT_TIMING;
          else if (state_r == ST_FAULT_TIMING)
            state_nxt = ST_ON;
        end
        ST_FAULT:
          if (!sense.enable_filt)
            state_nxt = ST_OFF;
          else if (retry_mode_r)
            state_nxt = ST_COOLDOWN;
        ST_COOLDOWN:
          if (!sense.enable_filt)
            state_nxt = ST_OFF;
          else if (!sense.timer_lower)
            state_nxt = ST_RAMP;
        default:
          state_nxt = ST_RESET;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state_r <= STATE_RESET;
    else
      state_r <= state_nxt;
  end

  // Timing node current source per state, in ST_FAULT chosen by retry mode
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      timer_sel <= TIMER_RESET;
    else
    begin
      unique case (state_nxt)
        ST_INIT_CHARGE: timer_sel <= TIMER_UP_5UA;
        ST_FAULT_TIMING: timer_sel <= TIMER_UP_60UA;
        ST_COOLDOWN: timer_sel <= TIMER_DOWN_2UA;
        ST_FAULT: timer_sel <= retry_mode_r ? TIMER_DOWN_2UA : TIMER_DOWN_100UA;
        ST_RESET: timer_sel <= TIMER_DOWN_100UA;
        ST_INIT_DISCHARGE: timer_sel <= TIMER_DOWN_100UA;
        ST_OFF: timer_sel <= TIMER_DOWN_100UA;
        ST_RAMP: timer_sel <= TIMER_DOWN_100UA;
        ST_ON: timer_sel <= TIMER_DOWN_100UA;
        default: timer_sel <= TIMER_DOWN_100UA;
      endcase
    end
  end

  // Gate drive mode, fast trip overrides everything except ST_RESET, which holds GATE_HOLD_25MA
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      gate_mode <= GATE_RESET;
    else if (state_nxt == ST_RESET)
      gate_mode <= GATE_HOLD_25MA;
    else if (sense.fast_trip)
      gate_mode <= GATE_STRONG_DOWN;
    else
    begin
      unique case (state_nxt)
        ST_INIT_CHARGE, ST_INIT_DISCHARGE, ST_OFF: gate_mode <= GATE_HOLD_25MA;
        ST_RAMP: gate_mode <= sense.linear_limit ? GATE_REGULATE : GATE_PULL_UP;
        ST_FAULT_TIMING: gate_mode <= sense.linear_limit ? GATE_REGULATE : GATE_PULL_UP;
        ST_ON: gate_mode <= GATE_FULL_ON;
        default: gate_mode <= GATE_STRONG_DOWN;
      endcase
    end
  end

  // Fault flag while faulted or cooling down
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      fault_flag <= 1'b0;
    else
      fault_flag <= (state_nxt == ST_FAULT) || (state_nxt == ST_COOLDOWN);
  end

  // Power good only while fully on and not tripped
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      power_good <= 1'b0;
    else
      power_good <= (state_nxt == ST_ON) && !sense.fast_trip;
  end
endmodule
`default_nettype wire

// file: tb/timing_cap_model.sv
// Timing capacitor model behind the timer comparators
`timescale 1ns/1ps
`default_nettype none
module timing_cap_model (
  input wire logic clock,
  input wire hot_swap_pkg::timer_sel_t timer_sel,
  output logic upper,
  output logic lower
);
  import hot_swap_pkg::*;
  int v = 0;
  always @(posedge clock)
  begin
    case (timer_sel)
      TIMER_UP_5UA: v <= v + 1;
      TIMER_UP_60UA: v <= v + 3;
      TIMER_DOWN_2UA: v <= (v > 0) ? v - 1 : 0;
      TIMER_DOWN_100UA: v <= (v > 20) ? v - 20 : 0;
      default: v <= v;
    endcase
  end
  assign upper = v >= 130;
  assign lower = v >= 20;
endmodule
`default_nettype wire

// file: tb/hot_swap_checker.sv
// Port assertions for the hot swap sequencer
`timescale 1ns/1ps
`default_nettype none
module hot_swap_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic supply_lockout_ok,
  input wire logic enable_request,
  input wire logic sense_fault_timing,
  input wire logic sense_linear_limit,
  input wire logic sense_fast_trip,
  input wire logic timing_upper_threshold,
  input wire logic timing_lower_threshold,
  input wire logic auto_retry,
  input wire hot_swap_pkg::timer_sel_t timer_sel,
  input wire hot_swap_pkg::gate_mode_t gate_mode,
  input wire logic fault_flag,
  input wire logic power_good
);
  import hot_swap_pkg::*;
  logic [9:0] low_cnt_r;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);
  // Cycles the enable request has been low
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      low_cnt_r <= 10'h000;
    else if (enable_request)
      low_cnt_r <= 10'h000;
    else if (low_cnt_r != 10'h3ff)
      low_cnt_r <= low_cnt_r + 10'h001;
  end
  sequence fast_held;
    (gate_mode == GATE_FULL_ON && sense_fast_trip) ##1 sense_fast_trip [*5];
  endsequence
  sequence ramp_over;
    (gate_mode == GATE_PULL_UP && sense_fault_timing) ##1 sense_fault_timing [*5];
  endsequence
  gate_onehot_a: assert property ($onehot(gate_mode))
    else $error("gate mode not one hot");
  lockout_hold_a: assert property (!supply_lockout_ok [*8] |-> gate_mode == GATE_HOLD_25MA && timer_sel == TIMER_DOWN_100UA)
    else $error("lockout hold");
  enable_off_a: assert property (low_cnt_r >= 10'(ENABLE_FILTER_CYCLES + 8) |-> gate_mode == GATE_HOLD_25MA)
    else $error("enable low gate");
  fault_timer_a: assert property (ramp_over |-> timer_sel == TIMER_UP_60UA || fault_flag)
    else $error("fault timer");
  full_on_a: assert property (gate_mode == GATE_FULL_ON |-> power_good && timer_sel == TIMER_DOWN_100UA)
    else $error("full on");
  fault_decl_a: assert property (gate_mode == GATE_REGULATE && sense_fault_timing && timing_upper_threshold |-> ##[1:6] fault_flag)
    else $error("fault not declared");
  fault_gate_a: assert property (fault_flag |-> gate_mode == GATE_STRONG_DOWN)
    else $error("fault gate");
  fast_trip_a: assert property (fast_held |-> gate_mode == GATE_STRONG_DOWN)
    else $error("fast trip");
endmodule
`default_nettype wire

// file: tb/hot_swap_sequencer_test.sv
// Self-checking bench for the hot swap sequencer
`timescale 1ns/1ps
`default_nettype none
module hot_swap_sequencer_test;
  import hot_swap_pkg::*;
  logic clock = 0;
  logic rst_b = 0;
  logic sup = 0;
  logic en = 1;
  logic ft = 1;
  logic lin = 0;
  logic fast = 0;
  logic auto = 0;
  wire logic upper;
  wire logic lower;
  timer_sel_t timer_sel;
  gate_mode_t gate_mode;
  logic fault_flag;
  logic power_good;
  int error_cnt = 0;
  int tests_run = 0;
  logic [4:0] exp_q[$];
  logic [4:0] exp;
  always #4 clock = ~clock;
  hot_swap_sequencer DUT (.clock(clock), .rst_b(rst_b), .supply_lockout_ok(sup), .enable_request(en),
    .sense_fault_timing(ft), .sense_linear_limit(lin), .sense_fast_trip(fast), .timing_upper_threshold(upper),
    .timing_lower_threshold(lower), .auto_retry(auto), .timer_sel(timer_sel), .gate_mode(gate_mode),
    .fault_flag(fault_flag), .power_good(power_good));
  timing_cap_model cap (.clock(clock), .timer_sel(timer_sel), .upper(upper), .lower(lower));
  task automatic check(input string what, input logic [4:0] seen, input logic [4:0] want);
    tests_run++;
    if (seen !== want)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wait_gate(input gate_mode_t g);
    int n;
    n = 0;
    while (gate_mode !== g && n < 2000)
    begin
      @(posedge clock);
      #1;
      n++;
    end
    check("gate_wait", gate_mode, g);
  endtask
  // Ramp under over-current until the timer declares a fault
  task automatic ramp_to_fault;
    exp_q.push_back(GATE_PULL_UP);
    wait_gate(GATE_PULL_UP);
    lin = 1;
    exp_q.push_back(GATE_REGULATE);
    exp_q.push_back(GATE_STRONG_DOWN);
    wait_gate(GATE_STRONG_DOWN);
    check("fault_flag", {4'h0, fault_flag}, 5'h01);
    check("timer_sel", timer_sel, auto ? TIMER_DOWN_2UA : TIMER_DOWN_100UA);
    lin = 0;
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    @(posedge rst_b);
    forever
    begin
      @(gate_mode);
      #1;
      exp = (exp_q.size() > 0) ? exp_q.pop_front() : 5'h00;
      check("gate_mode", gate_mode, exp);
      if (exp == GATE_FULL_ON)
        check("power_good", {4'h0, power_good}, 5'h01);
    end
  end
  initial
  begin
    #(8 * 20000);
    error_cnt++;
    tally_and_finish();
  end
  initial
  begin
    void'($urandom(63839));
    tick(5);
    rst_b = 1;
    tick(30);
    sup = 1;
    exp_q.push_back(GATE_PULL_UP);
    wait_gate(GATE_PULL_UP);
    lin = 1;
    exp_q.push_back(GATE_REGULATE);
    tick(8);
    ft = 0;
    lin = 0;
    exp_q.push_back(GATE_FULL_ON);
    wait_gate(GATE_FULL_ON);
    fast = 1;
    exp_q.push_back(GATE_STRONG_DOWN);
    exp_q.push_back(GATE_FULL_ON);
    tick(10);
    fast = 0;
    wait_gate(GATE_FULL_ON);
    en = 0;
    tick(50 + $urandom % 250);
    en = 1;
    tick(400);
    for (int i = 0; i < 2; i++)
    begin
      en = 0;
      exp_q.push_back(GATE_HOLD_25MA);
      wait_gate(GATE_HOLD_25MA);
      tick(8);
      ft = 1;
      en = 1;
      ramp_to_fault();
      tick(300);
    end
    exp_q.push_back(GATE_HOLD_25MA);
    rst_b = 0;
    auto = 1;
    tick(5);
    rst_b = 1;
    ramp_to_fault();
    exp_q.push_back(GATE_PULL_UP);
    exp_q.push_back(GATE_STRONG_DOWN);
    wait_gate(GATE_PULL_UP);
    wait_gate(GATE_STRONG_DOWN);
    exp_q.push_back(GATE_HOLD_25MA);
    rst_b = 0;
    tick(5);
    check("pending", 5'(exp_q.size()), 5'h00);
    tally_and_finish();
  end
endmodule
bind hot_swap_sequencer hot_swap_checker chk (
  .clock(clock),
  .rst_b(rst_b),
  .supply_lockout_ok(supply_lockout_ok),
  .enable_request(enable_request),
  .sense_fault_timing(sense_fault_timing),
  .sense_linear_limit(sense_linear_limit),
  .sense_fast_trip(sense_fast_trip),
  .timing_upper_threshold(timing_upper_threshold),
  .timing_lower_threshold(timing_lower_threshold),
  .auto_retry(auto_retry),
  .timer_sel(timer_sel),
  .gate_mode(gate_mode),
  .fault_flag(fault_flag),
  .power_good(power_good)
);
`default_nettype wire
